/* shared/csp_pkg.sv */
// Shared constants for the codec serial port.
package csp_pkg;
  // ----------------------------------------------------------------
  // Register map and widths
  // ----------------------------------------------------------------
  localparam int         DATA_W          = 16;
  localparam int         BYTE_W          = 8;
  localparam int         ADDR_W          = 16;
  localparam logic [15:0] TX_BUFFER_ADDR = 16'h0000;
  localparam logic [15:0] RX_BUFFER_ADDR = 16'h0001;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic        WORD_SIZE_RST   = 1'b0;
  localparam logic        SYNC_SRC_RST    = 1'b0;
  localparam logic        SYNC_REQ_RST    = 1'b1;
  localparam logic [15:0] BUFFER_RST      = 16'h0000;
  // ----------------------------------------------------------------
  // Bit counts per transfer
  // ----------------------------------------------------------------
  localparam logic [4:0]  WORD_BITS       = 5'h10;
  localparam logic [4:0]  BYTE_BITS       = 5'h08;
endpackage

/* hdl/codec_serial_port.sv */
// Full-duplex synchronous serial port with transmit and receive halves.
`timescale 1ns/10ps
// What this block does
// - Word size bit 0 gives 16-bit transfers, 1 gives low-byte transfers.
// - Reset clears the word size bit, starting in 16-bit mode.
// - Sync source 1 drives transmit sync and pulses it per buffer write.
// - Sync source 0 makes transmit sync an input awaited before sending.
// - Reset clears sync source, floats serial out, ends transfers.
// - With sync required, each transmit sync loads shifter and starts.
// - A sync before the last bit aborts and restarts with a new word.
// - Sync required is set by reset and its set operation, cleared only by its clear operation.
// - Transmission starts when transmit sync falls at a rising clock edge.
// - Transmit data leaves MSB first, changing on rising clock edges.
// - Transmit done follows the final bit; output floats when idle.
// - After receive sync falls, input is sampled on falling edges, MSB first.
// - After a full word the buffer is loaded and receive done raised.
// - Transmit buffer is copied into the shifter when a word begins.
// - Several buffer writes before a load leave only the last one.
// - Bus release finishes the current word, then floats serial out.
// - Internal sync pulses at the third rising edge after a buffer write.
// - A rewrite before the word ends gives another pulse, back to back.
// - In byte mode the old low byte moves up as a new byte arrives.
// - Bit clocks may stop when idle; no minimum clock rate.
module codec_serial_port (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata,
  input  wire logic        format_load,
  input  wire logic        format_value,
  input  wire logic        sync_source_load,
  input  wire logic        sync_source_value,
  input  wire logic        sync_mode_set_op,
  input  wire logic        sync_mode_clear_op,
  input  wire logic        bus_release_req,
  output logic      [2:0]  status_word_one,
  output logic             transmit_done_irq,
  output logic             receive_done_irq,
  input  wire logic        transmit_bit_clock,
  input  wire logic        receive_bit_clock,
  output logic             serial_out,
  output logic             serial_out_oe_n,
  input  wire logic        transmit_sync_in,
  output logic             transmit_sync_out,
  output logic             transmit_sync_oe_n,
  input  wire logic        serial_in,
  input  wire logic        receive_sync
);

  function automatic logic [4:0] word_bits(input logic byte_mode);
    word_bits = byte_mode ? csp_pkg::BYTE_BITS : csp_pkg::WORD_BITS;
  endfunction

  // ----------------------------------------------------------------
  // Core side: control bits and buffers
  // ----------------------------------------------------------------
  logic        word_size_select_reg;
  logic        transmit_sync_source_reg;
  logic        sync_required_reg;
  logic [15:0] transmit_buffer_reg;
  logic [15:0] receive_buffer_reg;
  logic [15:0] receive_buffer_next;
  logic        tx_wr_tgl_reg;
  logic [1:0]  tx_done_sync_reg;
  logic        tx_done_seen_reg;
  logic [1:0]  rx_done_sync_reg;
  logic        rx_done_seen_reg;
  logic        tx_done_tgl_reg;
  logic        rx_done_tgl_reg;
  logic [15:0] rx_word_reg;
  wire         wr_tx_buf = mem_wr && (mem_addr == csp_pkg::TX_BUFFER_ADDR);
  wire         wr_rx_buf = mem_wr && (mem_addr == csp_pkg::RX_BUFFER_ADDR);
  wire         tx_done_evt = tx_done_sync_reg[1] ^ tx_done_seen_reg;
  wire         rx_done_evt = rx_done_sync_reg[1] ^ rx_done_seen_reg;

  assign receive_buffer_next = word_size_select_reg ?
    {receive_buffer_reg[7:0], rx_word_reg[7:0]} : rx_word_reg;
  assign mem_rdata = (mem_addr == csp_pkg::TX_BUFFER_ADDR) ?
    transmit_buffer_reg :
    ((mem_addr == csp_pkg::RX_BUFFER_ADDR) ? receive_buffer_reg : 16'h0000);
  assign status_word_one = {sync_required_reg, transmit_sync_source_reg,
                            word_size_select_reg};
  assign transmit_done_irq = tx_done_evt;
  assign receive_done_irq  = rx_done_evt;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      word_size_select_reg     <= csp_pkg::WORD_SIZE_RST;
      transmit_sync_source_reg <= csp_pkg::SYNC_SRC_RST;
      sync_required_reg        <= csp_pkg::SYNC_REQ_RST;
    end else begin
      if (format_load) begin
        word_size_select_reg <= format_value;
      end
      if (sync_source_load) begin
        transmit_sync_source_reg <= sync_source_value;
      end
      if (sync_mode_set_op) begin
        sync_required_reg <= 1'b1;
      end else if (sync_mode_clear_op) begin
        sync_required_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      transmit_buffer_reg <= csp_pkg::BUFFER_RST;
      receive_buffer_reg  <= csp_pkg::BUFFER_RST;
      tx_wr_tgl_reg       <= 1'b0;
    end else begin
      if (wr_tx_buf) begin
        transmit_buffer_reg <= mem_wdata;
        tx_wr_tgl_reg       <= ~tx_wr_tgl_reg;
      end
      if (rx_done_evt) begin
        receive_buffer_reg <= receive_buffer_next;
      end else if (wr_rx_buf) begin
        receive_buffer_reg <= mem_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_done_sync_reg <= 2'h0;
      tx_done_seen_reg <= 1'b0;
      rx_done_sync_reg <= 2'h0;
      rx_done_seen_reg <= 1'b0;
    end else begin
      tx_done_sync_reg <= {tx_done_sync_reg[0], tx_done_tgl_reg};
      tx_done_seen_reg <= tx_done_sync_reg[1];
      rx_done_sync_reg <= {rx_done_sync_reg[0], rx_done_tgl_reg};
      rx_done_seen_reg <= rx_done_sync_reg[1];
    end
  end

  // ----------------------------------------------------------------
  // Transmit half on the transmit bit clock
  // ----------------------------------------------------------------
  logic [1:0]  tx_wr_sync_reg;
  logic        tx_wr_seen_reg;
  logic [1:0]  tx_fo_sync_reg;
  logic [1:0]  tx_src_sync_reg;
  logic [1:0]  tx_req_sync_reg;
  logic [1:0]  tx_hold_sync_reg;
  logic        tx_pending_reg;
  logic [15:0] tx_snap_reg;
  logic        tx_fs_reg;
  logic        tx_fs_in_reg;
  logic        tx_active_reg;
  logic [4:0]  tx_cnt_reg;
  logic [15:0] transmit_shifter_reg;
  logic        serial_out_reg;
  wire         tx_fo    = tx_fo_sync_reg[1];
  wire         tx_src   = tx_src_sync_reg[1];
  wire         tx_req   = tx_req_sync_reg[1];
  wire         tx_hold  = tx_hold_sync_reg[1];
  wire         tx_wr_ev = tx_wr_sync_reg[1] ^ tx_wr_seen_reg;
  wire         tx_last  = tx_active_reg && (tx_cnt_reg == 5'h01);
  wire         tx_fall  = tx_fs_in_reg && !transmit_sync_in;
  wire         tx_has_data = tx_pending_reg || tx_wr_ev;
  wire         tx_pulse = tx_src && tx_has_data && !tx_fs_reg && !tx_hold &&
                          (!tx_active_reg || tx_last);
  wire         tx_ext_go = !tx_src && tx_fall && !tx_hold &&
                           (tx_req || !tx_active_reg);
  wire         tx_cont  = !tx_req && tx_last && !tx_hold;
  wire         tx_start = (tx_src ? tx_fs_reg : tx_ext_go) || tx_cont;
  wire [15:0]  tx_load  = tx_fo ? {tx_snap_reg[7:0], 8'h00}
                                : tx_snap_reg;

  assign serial_out         = serial_out_reg;
  assign serial_out_oe_n    = !tx_active_reg;
  assign transmit_sync_out  = tx_fs_reg;
  assign transmit_sync_oe_n = !tx_src;

  always_ff @(posedge transmit_bit_clock or negedge rstn) begin
    if (!rstn) begin
      tx_wr_sync_reg   <= 2'h0;
      tx_wr_seen_reg   <= 1'b0;
      tx_fo_sync_reg   <= 2'h0;
      tx_src_sync_reg  <= 2'h0;
      tx_req_sync_reg  <= 2'h3;
      tx_hold_sync_reg <= 2'h0;
      tx_fs_in_reg     <= 1'b0;
    end else begin
      tx_wr_sync_reg   <= {tx_wr_sync_reg[0], tx_wr_tgl_reg};
      tx_wr_seen_reg   <= tx_wr_sync_reg[1];
      tx_fo_sync_reg   <= {tx_fo_sync_reg[0], word_size_select_reg};
      tx_src_sync_reg  <= {tx_src_sync_reg[0], transmit_sync_source_reg};
      tx_req_sync_reg  <= {tx_req_sync_reg[0], sync_required_reg};
      tx_hold_sync_reg <= {tx_hold_sync_reg[0], bus_release_req};
      tx_fs_in_reg     <= transmit_sync_in;
    end
  end

  always_ff @(posedge transmit_bit_clock or negedge rstn) begin
    if (!rstn) begin
      tx_snap_reg    <= csp_pkg::BUFFER_RST;
      tx_pending_reg <= 1'b0;
      tx_fs_reg      <= 1'b0;
    end else begin
      if (tx_wr_ev) begin
        tx_snap_reg <= transmit_buffer_reg;
      end
      tx_fs_reg <= tx_pulse;
      if (tx_pulse || (tx_start && !tx_src)) begin
        tx_pending_reg <= 1'b0;
      end else if (tx_wr_ev) begin
        tx_pending_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge transmit_bit_clock or negedge rstn) begin
    if (!rstn) begin
      tx_active_reg        <= 1'b0;
      tx_cnt_reg           <= 5'h00;
      transmit_shifter_reg <= csp_pkg::BUFFER_RST;
      serial_out_reg       <= 1'b0;
      tx_done_tgl_reg      <= 1'b0;
    end else begin
      if (tx_start) begin
        tx_active_reg        <= 1'b1;
        tx_cnt_reg           <= word_bits(tx_fo);
        serial_out_reg       <= tx_load[15];
        transmit_shifter_reg <= {tx_load[14:0], 1'b0};
      end else if (tx_active_reg && tx_cnt_reg > 5'h01) begin
        serial_out_reg       <= transmit_shifter_reg[15];
        transmit_shifter_reg <= {transmit_shifter_reg[14:0], 1'b0};
        tx_cnt_reg           <= tx_cnt_reg - 5'h01;
      end else if (tx_last) begin
        tx_active_reg <= 1'b0;
        tx_cnt_reg    <= 5'h00;
      end
      if (tx_last) begin
        tx_done_tgl_reg <= ~tx_done_tgl_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive half on falling receive bit clock edges
  // ----------------------------------------------------------------
  logic [1:0]  rx_fo_sync_reg;
  logic [1:0]  rx_req_sync_reg;
  logic        rx_fs_prev_reg;
  logic        rx_active_reg;
  logic [4:0]  rx_cnt_reg;
  logic [15:0] receive_shifter_reg;
  wire         rx_fo    = rx_fo_sync_reg[1];
  wire         rx_req   = rx_req_sync_reg[1];
  wire         rx_fall  = rx_fs_prev_reg && !receive_sync;
  wire         rx_begin = rx_fall && (rx_req || !rx_active_reg);
  wire [4:0]   rx_bits  = word_bits(rx_fo);
  wire [15:0]  rx_shift = {receive_shifter_reg[14:0], serial_in};
  wire [4:0]   rx_cnt_next = rx_begin ? 5'h01 : rx_cnt_reg + 5'h01;
  wire         rx_full  = (rx_begin || rx_active_reg) &&
                          (rx_cnt_next == rx_bits);

  always_ff @(negedge receive_bit_clock or negedge rstn) begin
    if (!rstn) begin
      rx_fo_sync_reg  <= 2'h0;
      rx_req_sync_reg <= 2'h3;
      rx_fs_prev_reg  <= 1'b0;
    end else begin
      rx_fo_sync_reg  <= {rx_fo_sync_reg[0], word_size_select_reg};
      rx_req_sync_reg <= {rx_req_sync_reg[0], sync_required_reg};
      rx_fs_prev_reg  <= receive_sync;
    end
  end

  always_ff @(negedge receive_bit_clock or negedge rstn) begin
    if (!rstn) begin
      rx_active_reg       <= 1'b0;
      rx_cnt_reg          <= 5'h00;
      receive_shifter_reg <= csp_pkg::BUFFER_RST;
      rx_word_reg         <= csp_pkg::BUFFER_RST;
      rx_done_tgl_reg     <= 1'b0;
    end else begin
      if (rx_begin || rx_active_reg) begin
        receive_shifter_reg <= rx_shift;
        rx_cnt_reg          <= rx_full ? 5'h00 : rx_cnt_next;
        rx_active_reg       <= !rx_full || !rx_req;
      end
      if (rx_full) begin
        rx_word_reg     <= rx_shift;
        rx_done_tgl_reg <= ~rx_done_tgl_reg;
      end
    end
  end

endmodule

/* verif/csp_chk.sv */
// Concurrent checks on the codec serial port pins.
`timescale 1ns/10ps
module csp_chk (
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       format_load,
  input wire logic       format_value,
  input wire logic       sync_mode_set_op,
  input wire logic       sync_mode_clear_op,
  input wire logic       bus_release_req,
  input wire logic [2:0] status_word_one,
  input wire logic       transmit_done_irq,
  input wire logic       transmit_bit_clock,
  input wire logic       serial_out_oe_n,
  input wire logic       transmit_sync_out,
  input wire logic       transmit_sync_oe_n
);
  property p_fmt; @(posedge ref_clk) disable iff (!rstn)
    format_load |=> status_word_one[0] == $past(format_value); endproperty
  a_fmt: assert property (p_fmt) else $error("Word size not loaded.");
  property p_set; @(posedge ref_clk) disable iff (!rstn)
    sync_mode_set_op |=> status_word_one[2]; endproperty
  a_set: assert property (p_set) else $error("Sync mode not set.");
  property p_clr; @(posedge ref_clk) disable iff (!rstn)
    sync_mode_clear_op |=> !status_word_one[2]; endproperty
  a_clr: assert property (p_clr) else $error("Sync mode not cleared.");
  property p_dir; @(posedge ref_clk) disable iff (!rstn)
    $rose(status_word_one[1]) |-> ##[0:4] !transmit_sync_oe_n; endproperty
  a_dir: assert property (p_dir) else $error("Sync pin not driven.");
  property p_one; @(posedge transmit_bit_clock) disable iff (!rstn)
    transmit_sync_out |=> !transmit_sync_out; endproperty
  a_one: assert property (p_one) else $error("Sync pulse too long.");
  property p_go; @(posedge transmit_bit_clock) disable iff (!rstn)
    transmit_sync_out && !transmit_sync_oe_n && !bus_release_req
    |=> !serial_out_oe_n; endproperty
  a_go: assert property (p_go) else $error("Word did not start.");
  property p_len; @(posedge transmit_bit_clock) disable iff (!rstn)
    $fell(serial_out_oe_n) |-> !serial_out_oe_n [*8]; endproperty
  a_len: assert property (p_len) else $error("Word cut short.");
  property p_done; @(posedge ref_clk) disable iff (!rstn)
    $rose(serial_out_oe_n) |-> ##[1:6] transmit_done_irq; endproperty
  a_done: assert property (p_done) else $error("No transmit done.");
endmodule
bind codec_serial_port csp_chk csp_chk_inst (.*);

/* verif/csp_partner.sv */
// Codec-side model: bit clocks, frame syncs and serial data.
`timescale 1ns/10ps
module csp_partner (
  output logic      transmit_bit_clock,
  output logic      receive_bit_clock,
  output logic      serial_in,
  output logic      receive_sync,
  output logic      transmit_sync_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n
);
  logic bits[$];
  initial begin
    {transmit_bit_clock, receive_bit_clock} = 2'b00;
    {serial_in, receive_sync, transmit_sync_in} = 3'b000;
  end
  initial #3.1 forever #6 transmit_bit_clock = ~transmit_bit_clock;
  initial #1.7 forever #6 receive_bit_clock = ~receive_bit_clock;
  always @(negedge transmit_bit_clock) begin
    if (serial_out_oe_n === 1'b0)
      bits.push_back(serial_out);
  end
  task automatic tx_frame();
    @(posedge transmit_bit_clock) #1 transmit_sync_in = 1'b1;
    @(posedge transmit_bit_clock) #1 transmit_sync_in = 1'b0;
  endtask
  task automatic rx_word(input logic [15:0] w, input int n);
    @(posedge receive_bit_clock) #1 receive_sync = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge receive_bit_clock) #1 serial_in = w[i];
      receive_sync = 1'b0;
    end
    @(posedge receive_bit_clock) #1 serial_in = ~serial_in;
  endtask
endmodule

/* verif/tb.sv */
// Self-checking bench for the codec serial port.
`timescale 1ns/10ps
module tb;
  logic        ref_clk = 1'b0, rstn = 1'b0, mem_wr = 1'b0;
  logic        format_load = 1'b0, format_value = 1'b0;
  logic        sync_source_load = 1'b0, sync_source_value = 1'b0;
  logic        sync_mode_set_op = 1'b0, sync_mode_clear_op = 1'b0;
  logic        bus_release_req = 1'b0;
  logic [15:0] mem_addr = 16'h0000, mem_wdata = 16'h0000, mem_rdata;
  logic [2:0]  status_word_one;
  logic        transmit_done_irq, receive_done_irq, serial_out;
  logic        serial_out_oe_n, transmit_sync_out, transmit_sync_oe_n;
  logic        transmit_bit_clock, receive_bit_clock, serial_in;
  logic        receive_sync, transmit_sync_in;
  int          checked = 0, mismatches = 0;
  codec_serial_port codec_serial_port_inst (.*);
  csp_partner csp_partner_inst (.*);
  always #12.5 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_bits(input logic [15:0] w, input int n, input int at);
    for (int i = 0; i < n; i++)
      chk("serial bit", {15'h0000, w[n-1-i]},
          {15'h0000, csp_partner_inst.bits[at+i]});
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk) #1;
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1'b1;
    @(posedge ref_clk) #1 mem_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge ref_clk) #1 mem_addr = a;
    #2 chk("read data", e, mem_rdata);
  endtask
  task automatic ctl(input logic [2:0] sel, input logic v);
    @(posedge ref_clk) #1;
    {sync_source_load, format_load} = sel[1:0];
    {format_value, sync_source_value} = {v, v};
    sync_mode_set_op = sel[2] & v;
    sync_mode_clear_op = sel[2] & ~v;
    @(posedge ref_clk) #1;
    {format_load, sync_source_load, sync_mode_set_op} = 3'b000;
    sync_mode_clear_op = 1'b0;
  endtask
  task automatic wait_irq(input logic rx);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 400 && !hit; i++) begin
      @(posedge ref_clk) #1;
      hit = rx ? receive_done_irq === 1'b1 : transmit_done_irq === 1'b1;
    end
    chk("done flag", 16'h0001, {15'h0000, hit});
  endtask
  task automatic wait_bits(input int n);
    for (int i = 0; i < 400 && csp_partner_inst.bits.size() < n; i++)
      @(posedge ref_clk);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    int nb;
    repeat (8) @(posedge ref_clk);
    #1 rstn = 1'b1;
    chk("status", {13'h0000, csp_pkg::SYNC_REQ_RST, 2'b00},
        {13'h0000, status_word_one});
    chk("out float", 16'h0001, {15'h0000, serial_out_oe_n});
    chk("sync dir", 16'h0001, {15'h0000, transmit_sync_oe_n});
    rd(16'h0002, 16'h0000);
    wr(16'h0001, 16'h1234);
    rd(16'h0001, 16'h1234);
    $display("Test reset and registers done");
    ctl(3'b010, 1'b1);
    wr(16'h0000, 16'h5A3C);
    wait_bits(4);
    wr(16'h0000, 16'h1111);
    wr(16'h0000, 16'hC96E);
    wait_irq(1'b0);
    wait_irq(1'b0);
    chk("bit count", 16'h0020, 16'(csp_partner_inst.bits.size()));
    chk_bits(16'h5A3C, 16, 0);
    chk_bits(16'hC96E, 16, 16);
    $display("Test internal sync words done");
    csp_partner_inst.rx_word(16'h9A5E, 16);
    wait_irq(1'b1);
    rd(16'h0001, 16'h9A5E);
    ctl(3'b001, 1'b1);
    csp_partner_inst.bits.delete();
    wr(16'h0000, 16'h12C5);
    wait_irq(1'b0);
    chk("bit count", 16'h0008, 16'(csp_partner_inst.bits.size()));
    chk_bits(16'h00C5, 8, 0);
    csp_partner_inst.rx_word(16'h003C, 8);
    wait_irq(1'b1);
    csp_partner_inst.rx_word(16'h00A7, 8);
    wait_irq(1'b1);
    rd(16'h0001, 16'h3CA7);
    $display("Test byte mode done");
    ctl(3'b011, 1'b0);
    csp_partner_inst.bits.delete();
    wr(16'h0000, 16'h3C0F);
    repeat (30) @(posedge ref_clk);
    chk("idle bits", 16'h0000, 16'(csp_partner_inst.bits.size()));
    csp_partner_inst.tx_frame();
    wr(16'h0000, 16'h6B1D);
    repeat (2) @(posedge ref_clk);
    csp_partner_inst.tx_frame();
    wait_irq(1'b0);
    nb = csp_partner_inst.bits.size();
    chk("abort span", 16'h0001, {15'h0000, nb > 16 && nb < 32});
    chk_bits(16'h6B1D, 16, nb - 16);
    $display("Test external sync abort done");
    ctl(3'b100, 1'b0);
    chk("sync mode", 16'h0000, {15'h0000, status_word_one[2]});
    ctl(3'b100, 1'b1);
    chk("sync mode", 16'h0001, {15'h0000, status_word_one[2]});
    $display("Test sync mode ops done");
    ctl(3'b010, 1'b1);
    @(posedge ref_clk) #1 bus_release_req = 1'b1;
    repeat (4) @(posedge ref_clk);
    csp_partner_inst.bits.delete();
    wr(16'h0000, 16'hE718);
    repeat (40) @(posedge ref_clk);
    chk("held bits", 16'h0000, 16'(csp_partner_inst.bits.size()));
    $display("Test bus release done");
    complete_run();
  end
  initial begin
    #400000;
    mismatches++;
    complete_run();
  end
endmodule
